/* File: core/cdt_pkg.sv */
// Constants, register map and carrier types for the countdown timer block.
// Assumes one 200 MHz clock and a byte-wide register port of the host device.
// Notes on behaviour
// - Countdown runs only while timer enable set
// - Rate field picks 32, 8, 1, 0.5 Hz
// - Start value from low and high count registers
// - Zero start value keeps counter from running
// - Reaching zero completes one countdown period
// - Auto-reload restarts next period from start value
// - Each reload costs one extra tick
// - Completion sets done flag when irq enabled
// - Interrupt follows flag and irq enable; flag held until software clears it
// - Rate and reload change only while stopped
// - Count registers written only when enable, reload clear
// - Interrupt pin active low, open drain
// - Reset: stopped, no reload, 32 Hz, irqs off
package cdt_pkg;
    // Register offsets
    localparam logic [5:0] ADDR_MODE_CTRL = 6'h00;
    localparam logic [5:0] ADDR_IRQ_CTRL = 6'h01;
    localparam logic [5:0] ADDR_IRQ_FLAG = 6'h02;
    localparam logic [5:0] ADDR_COUNT_LO = 6'h18;
    localparam logic [5:0] ADDR_COUNT_HI = 6'h19;
    // Field positions
    localparam int BIT_TIMER_ENABLE = 1;
    localparam int BIT_AUTO_RELOAD = 2;
    localparam int BIT_RATE_LO = 5;
    localparam int BIT_RATE_HI = 6;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_DONE_FLAG = 1;
    // Reset values
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // Rate codes
    localparam logic [1:0] RATE_32HZ = 2'h0;
    localparam logic [1:0] RATE_8HZ = 2'h1;
    localparam logic [1:0] RATE_1HZ = 2'h2;
    localparam logic [1:0] RATE_HALF_HZ = 2'h3;
    // Crystal periods per tick, as masks on the crystal divider
    localparam logic [15:0] MASK_32HZ = 16'h03ff;
    localparam logic [15:0] MASK_8HZ = 16'h0fff;
    localparam logic [15:0] MASK_1HZ = 16'h7fff;
    localparam logic [15:0] MASK_HALF_HZ = 16'hffff;
    // Timing: system clock and crystal rates in Hz
    localparam longint CLOCK_HZ = 200000000;
    localparam longint XTAL_HZ = 32768;
    localparam int XTAL_DIV = int'(CLOCK_HZ / XTAL_HZ);

    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_ZERO} phase_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        phase_t phase;
        logic te;
        logic auto_reload_bit;
        logic [1:0] rate;
        logic timer_irq_enable;
        logic flag;
        logic [15:0] start_n;
        logic [15:0] cnt;
        logic [12:0] xtal_cnt;
        logic [15:0] div_cnt;
        logic [7:0] rdata;
        logic int_oe;
    } state_t;
endpackage

/* File: core/countdown_timer_interrupt.sv */
// Countdown timer with auto-reload, done flag and open-drain interrupt pin.
// Assumes register requests are single-cycle strobes synchronous to clock.
`timescale 1ns/1ps
module countdown_timer_interrupt import cdt_pkg::*; #(
    parameter int XTAL_DIVIDE = XTAL_DIV
) (
    input wire logic clock, // 200 MHz system clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire reg_req_t req, // Register read or write strobe
    output logic [7:0] rdata_q, // Read data, valid after rd
    output logic int_out_q, // Interrupt pin output level
    output logic int_oe_q // Interrupt pin pull-down enable
);
    state_t s_q;
    state_t s_d;
    logic xtal_en;
    logic tick;
    logic done;
    logic start;
    logic flag_clr;
    logic [15:0] mask;

    // Tick mask chosen by the rate field
    always_comb begin
        case (s_q.rate)
            RATE_32HZ: mask = MASK_32HZ;
            RATE_8HZ: mask = MASK_8HZ;
            RATE_1HZ: mask = MASK_1HZ;
            RATE_HALF_HZ: mask = MASK_HALF_HZ;
            default: mask = MASK_32HZ;
        endcase
    end

    // Crystal enable and source tick, free running so rates stay aligned
    assign xtal_en = (s_q.xtal_cnt == 13'(XTAL_DIVIDE - 1));
    assign tick = xtal_en && ((s_q.div_cnt & mask) == mask);
    assign flag_clr = req.wr && req.addr == ADDR_IRQ_FLAG && !req.wdata[BIT_DONE_FLAG];
    assign start = (s_q.phase == PH_IDLE) && s_q.te;
    assign done = (s_q.phase == PH_RUN) && tick && s_q.cnt == 16'h0001;

    // Next state: registers, divider, countdown sequencer
    always_comb begin
        s_d = s_q;
        s_d.xtal_cnt = xtal_en ? 13'h0000 : s_q.xtal_cnt + 13'h0001;
        if (xtal_en) begin
            s_d.div_cnt = s_q.div_cnt + 16'h0001;
        end
        if (req.wr) begin
            case (req.addr)
                ADDR_MODE_CTRL: begin
                    s_d.te = req.wdata[BIT_TIMER_ENABLE];
                    // Stored enable guards, so a stop-and-change write is refused
                    if (!s_q.te) begin
                        s_d.auto_reload_bit = req.wdata[BIT_AUTO_RELOAD];
                        s_d.rate = req.wdata[BIT_RATE_HI:BIT_RATE_LO];
                    end
                end
                ADDR_IRQ_CTRL: s_d.timer_irq_enable = req.wdata[BIT_IRQ_ENABLE];
                ADDR_COUNT_LO: begin
                    if (!s_q.te && !s_q.auto_reload_bit) begin
                        s_d.start_n[7:0] = req.wdata;
                    end
                end
                ADDR_COUNT_HI: begin
                    if (!s_q.te && !s_q.auto_reload_bit) begin
                        s_d.start_n[15:8] = req.wdata;
                    end
                end
                default: ;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_MODE_CTRL: s_d.rdata = {1'b0, s_q.rate, 2'b00, s_q.auto_reload_bit, s_q.te, 1'b0};
                ADDR_IRQ_CTRL: s_d.rdata = {6'h00, s_q.timer_irq_enable, 1'b0};
                ADDR_IRQ_FLAG: s_d.rdata = {6'h00, s_q.flag, 1'b0};
                ADDR_COUNT_LO: s_d.rdata = s_q.start_n[7:0];
                ADDR_COUNT_HI: s_d.rdata = s_q.start_n[15:8];
                default: s_d.rdata = 8'h00;
            endcase
        end
        case (s_q.phase)
            PH_IDLE: begin
                if (s_q.te) begin
                    s_d.cnt = s_q.start_n;
                    // A zero start value parks the counter at once
                    s_d.phase = (s_q.start_n == 16'h0000) ? PH_ZERO : PH_RUN;
                end
            end
            PH_RUN: begin
                if (tick) begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                    if (s_q.cnt == 16'h0001) begin
                        s_d.phase = PH_ZERO;
                    end
                end
            end
            PH_ZERO: begin
                // Reload spends one whole tick, so later periods are n+1
                if (tick && s_q.auto_reload_bit && s_q.start_n != 16'h0000) begin
                    s_d.cnt = s_q.start_n;
                    s_d.phase = PH_RUN;
                end
            end
            default: s_d.phase = PH_IDLE;
        endcase
        if (!s_q.te) begin
            s_d.phase = PH_IDLE;
        end
        // Set beats a clear landing in the same cycle
        if (flag_clr) begin
            s_d.flag = 1'b0;
        end
        if (done && s_q.timer_irq_enable) begin
            s_d.flag = 1'b1;
        end
        s_d.int_oe = s_d.flag && s_d.timer_irq_enable;
    end

    // State register; reset leaves the timer stopped at 32 Hz
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{phase: PH_IDLE, te: 1'b0, auto_reload_bit: 1'b0, rate: RATE_RESET,
                     timer_irq_enable: 1'b0, flag: 1'b0, start_n: COUNT_RESET, cnt: COUNT_RESET,
                     xtal_cnt: 13'h0000, div_cnt: 16'h0000, rdata: 8'h00, int_oe: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Open drain: the pin only ever pulls low
    assign rdata_q = s_q.rdata;
    assign int_out_q = 1'b0;
    assign int_oe_q = s_q.int_oe;

    sequence reload_tick_s;
        s_q.phase == PH_ZERO && tick && s_q.auto_reload_bit && s_q.te && s_q.start_n != 16'h0000;
    endsequence

    sequence reloaded_s;
        s_q.phase == PH_RUN && s_q.cnt == $past(s_q.start_n);
    endsequence

    stopped_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
        !s_q.te |=> s_q.phase == PH_IDLE)
        else $error("timer not idle while disabled");
    rate_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_q.rate == RATE_8HZ |-> mask == 16'h0fff)
        else $error("wrong tick mask for rate");
    rate_slow_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_q.rate == RATE_HALF_HZ |-> mask == 16'hffff)
        else $error("wrong tick mask for slowest rate");
    start_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        start |=> s_q.cnt == $past(s_q.start_n))
        else $error("start value not loaded");
    zero_park_a: assert property (@(posedge clock) disable iff (!rst_b)
        start && s_q.start_n == 16'h0000 |=> (s_q.phase == PH_ZERO && s_q.cnt == 16'h0000) [*2])
        else $error("zero start value ran");
    auto_reload_a: assert property (@(posedge clock) disable iff (!rst_b)
        reload_tick_s |=> reloaded_s)
        else $error("auto reload missed");
    flag_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        done && s_q.timer_irq_enable && s_q.te |=> s_q.flag ##1 (s_q.flag || $past(flag_clr)))
        else $error("done flag not set");
    flag_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_q.flag && !flag_clr |=> s_q.flag)
        else $error("flag dropped without clear");
    int_pin_a: assert property (@(posedge clock) disable iff (!rst_b)
        int_oe_q == (s_q.flag && s_q.timer_irq_enable) && !int_out_q)
        else $error("interrupt pin not tracking flag");
    rate_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
        s_q.te && req.wr && req.addr == ADDR_MODE_CTRL |=> $stable(s_q.rate) && $stable(s_q.auto_reload_bit))
        else $error("rate changed while running");
    count_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
        (s_q.te || s_q.auto_reload_bit) |=> $stable(s_q.start_n))
        else $error("count written while locked");
    reset_state_a: assert property (@(posedge clock)
        $rose(rst_b) |-> s_q.rate == RATE_32HZ && !s_q.timer_irq_enable && !s_q.te && !s_q.auto_reload_bit)
        else $error("reset defaults wrong");
endmodule

/* File: verif/countdown_timer_interrupt_tb.sv */
// Self-checking bench for the countdown timer: register model, lock rules, periods, interrupt.
// Assumes the design is built with a crystal divide of 2 so that ticks stay short.
`timescale 1ns/1ps
module countdown_timer_interrupt_tb import cdt_pkg::*;;
    localparam int XD = 2;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    reg_req_t req = '0;
    logic [7:0] rdata_q;
    logic int_out_q;
    logic int_oe_q;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h93dfbf44;
    // Register model kept by the bench
    logic m_te = 0, m_tar = 0, m_tie = 0, m_flag = 0;
    logic [1:0] m_rate = 2'h0;
    logic [7:0] m_lo = 8'h00, m_hi = 8'h00;
    int t1, t2, n1;
    logic [31:0] r;
    // Pin level with the external pull-up
    wire int_pin_b = int_oe_q ? int_out_q : 1'b1;

    countdown_timer_interrupt #(.XTAL_DIVIDE(XD)) u_countdown_timer_interrupt (
        .clock(clock), .rst_b(rst_b), .req(req), .rdata_q(rdata_q),
        .int_out_q(int_out_q), .int_oe_q(int_oe_q));

    always #2.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Writes obey the stored enable and reload bits, as the device does
    task automatic wr(logic [5:0] a, logic [7:0] d);
        case (a)
            ADDR_MODE_CTRL: begin
                if (!m_te) begin
                    m_tar = d[BIT_AUTO_RELOAD];
                    m_rate = d[6:5];
                end
                m_te = d[BIT_TIMER_ENABLE];
            end
            ADDR_IRQ_CTRL: m_tie = d[BIT_IRQ_ENABLE];
            ADDR_COUNT_LO: if (!m_te && !m_tar) m_lo = d;
            ADDR_COUNT_HI: if (!m_te && !m_tar) m_hi = d;
            default: ;
        endcase
        @(negedge clock);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clock);
        req.wr = 1'b0;
    endtask

    function automatic logic [7:0] mrd(logic [5:0] a);
        case (a)
            ADDR_MODE_CTRL: return {1'b0, m_rate, 2'b00, m_tar, m_te, 1'b0};
            ADDR_IRQ_CTRL: return {6'h00, m_tie, 1'b0};
            ADDR_IRQ_FLAG: return {6'h00, m_flag, 1'b0};
            ADDR_COUNT_LO: return m_lo;
            ADDR_COUNT_HI: return m_hi;
            default: return 8'h00;
        endcase
    endfunction

    task automatic rd(logic [5:0] a);
        @(negedge clock);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        req.rd = 1'b0;
        @(negedge clock);
        chk("rdata", {8'h00, mrd(a)}, {8'h00, rdata_q});
    endtask

    // Bounded wait for the pin to be pulled low; time stamped in clocks
    task automatic wait_irq(int lim, output int t);
        int n;
        n = 0;
        while (int_pin_b !== 1'b0 && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk("irq_seen", 1, n < lim);
        t = cyc;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard, well beyond the longest expected run
    initial begin
        #450000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        rd(ADDR_MODE_CTRL);
        rd(ADDR_IRQ_CTRL);
        rd(ADDR_COUNT_LO);
        // Random writes, locked fields must hold; 07h is unmapped
        for (int i = 0; i < 40; i++) begin
            r = xs();
            wr(r[9:8] == 2'd0 ? ADDR_MODE_CTRL : r[9:8] == 2'd1 ? ADDR_COUNT_LO :
               r[9:8] == 2'd2 ? ADDR_COUNT_HI : 6'h07, r[7:0]);
            rd(req.addr);
            chk("pin_idle", 1, int_pin_b);
        end
        // Stop first: a timer left running by the random writes must not finish once enabled
        wr(ADDR_MODE_CTRL, 8'h00);
        wr(ADDR_IRQ_CTRL, 8'h02);
        // Periods at two rates, start value 2, with reload
        for (int rt = 0; rt < 2; rt++) begin
            n1 = XD * (rt == 0 ? 1024 : 4096);
            wr(ADDR_MODE_CTRL, 8'h00);
            wr(ADDR_MODE_CTRL, 8'h00);
            wr(ADDR_COUNT_LO, 8'h02);
            wr(ADDR_COUNT_HI, 8'h00);
            wr(ADDR_MODE_CTRL, {1'b0, rt[1:0], 5'b00100});
            wr(ADDR_MODE_CTRL, {1'b0, rt[1:0], 5'b00110});
            t2 = cyc;
            wait_irq(2 * n1 + 8, t1);
            chk("first_period", 1, (t1 - t2) > n1 && (t1 - t2) <= 2 * n1 + 4);
            m_flag = 1;
            rd(ADDR_IRQ_FLAG);
            repeat (50) @(negedge clock);
            chk("pin_held", 0, int_pin_b);
            wr(ADDR_IRQ_FLAG, 8'h00);
            m_flag = 0;
            @(negedge clock);
            chk("pin_cleared", 1, int_pin_b);
            wait_irq(3 * n1 + 8, t2);
            chk("reload_period", 3 * n1, t2 - t1);
            wr(ADDR_MODE_CTRL, 8'h00);
            wr(ADDR_IRQ_FLAG, 8'h00);
        end
        // Zero start value never completes
        wr(ADDR_MODE_CTRL, 8'h00);
        wr(ADDR_COUNT_LO, 8'h00);
        wr(ADDR_MODE_CTRL, 8'h02);
        repeat (3 * XD * 1024) @(negedge clock);
        chk("zero_start", 1, int_pin_b);
        // Brief enable covers at most one tick; stopped timer never finishes
        wr(ADDR_MODE_CTRL, 8'h00);
        wr(ADDR_COUNT_LO, 8'h02);
        wr(ADDR_MODE_CTRL, 8'h02);
        wr(ADDR_MODE_CTRL, 8'h00);
        repeat (3 * XD * 1024) @(negedge clock);
        chk("stopped", 1, int_pin_b);
        rd(ADDR_IRQ_FLAG);
        stop_test();
    end
endmodule
